// *** rtl/channel_gain_and_sample_nco.v ***
`timescale 1ns/10ps
`include "channel_gain_consts.vh"


module channel_gain_and_sample_nco #(
   parameter DW          = 16,
   parameter ALIGN_DEPTH = `RAMP_ALIGN_DEPTH
) (
   input  wire                 sys_clk,
   input  wire                 sys_rst,
   input  wire [7:0]           hostAddr,
   input  wire [15:0]          hostWrData,
   input  wire                 hostWr,
   input  wire                 hostRd,
   output reg  [15:0]          hostRdData_q,
   input  wire                 txBurstEnable,
   input  wire signed [DW-1:0] shapedI,
   input  wire signed [DW-1:0] shapedQ,
   output wire signed [DW+1:0] gainI,
   output wire signed [DW+1:0] gainQ,
   output wire                 gainValid,
   output reg                  sampleClock_q,
   output wire                 sampleStrobe,
   output wire                 coarseStrobe,
   output reg  [3:0]           coarsePhase_q,
   output reg  [15:0]          finePhase_q,
   output wire                 leapCarry,
   output wire                 leapPreCarry
);

   // ----------------------------------------------------------------
   // control words
   // ----------------------------------------------------------------
   reg [15:0] leapDivHigh_q;
   reg [15:0] leapDivLow_q;
   reg [15:0] sampleIncHigh_q;
   reg [15:0] sampleIncMid_q;
   reg [15:0] sampleIncLow_q;
   reg [15:0] gainControl_q;
   reg [15:0] rampLenLat_q;
   reg [15:0] mainControl_q;
   reg [15:0] filterControl_q;
   reg [6:0]  rampMemAddr_q;

   wire [11:0] memRdData;
   wire [11:0] rampGain;
   wire [6:0]  rampPtr;
   wire        txEffective;
   wire        memWr;

   // host writes; memory data word goes through to the profile table
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         leapDivHigh_q   <= `RST_WORD;
         leapDivLow_q    <= `RST_WORD;
         sampleIncHigh_q <= `RST_WORD;
         sampleIncMid_q  <= `RST_WORD;
         sampleIncLow_q  <= `RST_WORD;
         gainControl_q   <= `RST_WORD;
         rampLenLat_q    <= `RST_WORD;
         mainControl_q   <= `RST_WORD;
         filterControl_q <= `RST_WORD;
         rampMemAddr_q   <= 7'h00;
      end else if (hostWr) begin
         case (hostAddr)
            `OFS_LEAP_DIV_HIGH:   leapDivHigh_q   <= hostWrData;
            `OFS_LEAP_DIV_LOW:    leapDivLow_q    <= hostWrData;
            `OFS_SAMPLE_INC_HIGH: sampleIncHigh_q <= hostWrData;
            `OFS_SAMPLE_INC_MID:  sampleIncMid_q  <= hostWrData;
            `OFS_SAMPLE_INC_LOW:  sampleIncLow_q  <= hostWrData;
            `OFS_GAIN_CONTROL:    gainControl_q   <= hostWrData;
            `OFS_RAMP_LEN_LAT:    rampLenLat_q    <= hostWrData;
            `OFS_MAIN_CONTROL:    mainControl_q   <= hostWrData;
            `OFS_FILTER_CONTROL:  filterControl_q <= hostWrData;
            `OFS_RAMP_MEM_ADDR:   rampMemAddr_q   <= hostWrData[6:0];
            default:              rampMemAddr_q   <= rampMemAddr_q;
         endcase
      end
   end

   assign memWr = hostWr && (hostAddr == `OFS_RAMP_MEM_DATA);

   // read back one cycle after the strobe; unmapped words read zero
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         hostRdData_q <= `RST_WORD;
      end else if (hostRd) begin
         case (hostAddr)
            `OFS_LEAP_DIV_HIGH:   hostRdData_q <= leapDivHigh_q;
            `OFS_LEAP_DIV_LOW:    hostRdData_q <= leapDivLow_q;
            `OFS_SAMPLE_INC_HIGH: hostRdData_q <= sampleIncHigh_q;
            `OFS_SAMPLE_INC_MID:  hostRdData_q <= sampleIncMid_q;
            `OFS_SAMPLE_INC_LOW:  hostRdData_q <= sampleIncLow_q;
            `OFS_GAIN_CONTROL:    hostRdData_q <= gainControl_q;
            `OFS_RAMP_LEN_LAT:    hostRdData_q <= rampLenLat_q;
            `OFS_MAIN_CONTROL:    hostRdData_q <= mainControl_q;
            `OFS_FILTER_CONTROL:  hostRdData_q <= filterControl_q;
            `OFS_RAMP_MEM_ADDR:   hostRdData_q <= {9'h000, rampMemAddr_q};
            `OFS_RAMP_MEM_DATA:   hostRdData_q <= {4'h0, memRdData};
            `OFS_CHANNEL_STATUS:  hostRdData_q <= {7'h00, txEffective, 1'b0, rampPtr};
            default:              hostRdData_q <= `RST_WORD;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // field decode
   // ----------------------------------------------------------------
   wire [47:0] sampleFrequencyWord  = {sampleIncHigh_q, sampleIncMid_q, sampleIncLow_q};
   wire [31:0] integerLeapDivisor   = {leapDivHigh_q, leapDivLow_q};
   wire [1:0]  phaseOffsetSel       = filterControl_q[`BIT_OFFSET_HI:`BIT_OFFSET_LO];
   wire [1:0]  ipSel                = filterControl_q[`BIT_IP_SEL_HI:`BIT_IP_SEL_LO];
   wire        leapEnable           = filterControl_q[`BIT_LEAP_ENABLE];
   wire        leapClrCoarse        = filterControl_q[`BIT_LEAP_CLR_COARSE];
   wire        leapClrFine          = filterControl_q[`BIT_LEAP_CLR_FINE];
   wire        rampEnable           = filterControl_q[`BIT_RAMP_ENABLE];
   wire        rampHold             = mainControl_q[`BIT_RAMP_HOLD];
   wire [11:0] gainMultiplier       = gainControl_q[`BIT_GAIN_MULT_HI:0];
   wire [2:0]  gainShiftCode        = gainControl_q[`BIT_GAIN_SHIFT_HI:`BIT_GAIN_SHIFT_LO];

   // coarse field width: log2 of the interpolation factor
   function [2:0] coarseBits;
      input [1:0] sel;
      begin
         case (sel)
            `IP_SEL_4: coarseBits = 3'd2;
            `IP_SEL_8: coarseBits = 3'd3;
            default:   coarseBits = 3'd4;
         endcase
      end
   endfunction

   wire [2:0]  coarseWidth = coarseBits(ipSel);
   wire [47:0] coarseMask  = ~({48{1'b1}} >> coarseWidth);
   wire [47:0] clearMask   = (leapClrCoarse ? coarseMask : 48'h0) |
                             (leapClrFine ? ~coarseMask : 48'h0);

   // ----------------------------------------------------------------
   // leap counter
   // ----------------------------------------------------------------
   // a zero divisor is taken as one, i.e. a carry on every clock
   reg  [31:0] leapCount_q;
   wire [31:0] leapDivEff = (integerLeapDivisor == 32'h0) ? 32'h1 : integerLeapDivisor;
   wire        leapAtEnd  = (leapCount_q >= leapDivEff - 32'h1);

   assign leapCarry    = leapEnable && leapAtEnd;
   assign leapPreCarry = leapEnable &&
                         ((leapDivEff == 32'h1) || (leapCount_q == leapDivEff - 32'h2));

   always @(posedge sys_clk) begin
      if (sys_rst || !leapEnable) begin
         leapCount_q <= 32'h0;
      end else if (leapAtEnd) begin
         leapCount_q <= 32'h0;
      end else begin
         leapCount_q <= leapCount_q + 32'h1;
      end
   end

   // ----------------------------------------------------------------
   // sample rate accumulator
   // ----------------------------------------------------------------
   reg  [47:0] phaseAcc_q;
   reg  [47:0] phaseOut_q;
   reg         coarseTap_q;
   wire [47:0] phaseOut  = phaseAcc_q + {phaseOffsetSel, 46'h0};
   wire [47:0] phaseFine = phaseOut << coarseWidth;
   wire [3:0]  coarseTop = phaseOut[47:44] >> (3'd4 - coarseWidth);
   wire        coarseTap = phaseOut_q[6'd48 - {3'd0, coarseWidth}];

   // carry clears chosen phase fields instead of adding that cycle
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         phaseAcc_q <= 48'h0;
      end else if (leapCarry) begin
         phaseAcc_q <= phaseAcc_q & ~clearMask;
      end else begin
         phaseAcc_q <= phaseAcc_q + sampleFrequencyWord;
      end
   end

   // offset output, sample clock and phases taken from registers
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         phaseOut_q    <= 48'h0;
         sampleClock_q <= 1'b0;
         coarsePhase_q <= 4'h0;
         finePhase_q   <= 16'h0000;
         coarseTap_q   <= 1'b0;
      end else begin
         phaseOut_q    <= phaseOut;
         sampleClock_q <= phaseOut[47];
         coarsePhase_q <= coarseTop;
         finePhase_q   <= phaseFine[47:32];
         coarseTap_q   <= coarseTap;
      end
   end

   // sample strobe leads each sample clock rise by one cycle; a coarse
   // step is a toggle of the coarse field's lowest bit, which holds only
   // while the increment stays below one step per clock
   assign sampleStrobe = phaseOut[47] & ~sampleClock_q;
   assign coarseStrobe = coarseTap ^ coarseTap_q;

   // ----------------------------------------------------------------
   // ramp profile and gain stages
   // ----------------------------------------------------------------
   ramp_gain_profile #(
      .ALIGN_DEPTH (ALIGN_DEPTH)
   ) u_ramp (
      .sys_clk       (sys_clk),
      .sys_rst       (sys_rst),
      .coarseStrobe  (coarseStrobe),
      .txBurstEnable (txBurstEnable),
      .rampEnable    (rampEnable),
      .rampHold      (rampHold),
      .latBypass     (rampLenLat_q[`BIT_LAT_BYPASS]),
      .latReduced    (rampLenLat_q[`BIT_LAT_REDUCED]),
      .rampLength    (rampLenLat_q[`BIT_RAMP_LEN_HI:0]),
      .memAddr       (rampMemAddr_q),
      .memWrData     (hostWrData[11:0]),
      .memWr         (memWr),
      .memRdData     (memRdData),
      .rampGain_q    (rampGain),
      .rampPtr_q     (rampPtr),
      .txEffective   (txEffective)
   );

   gain_scaler #(
      .DW (DW)
   ) u_gain (
      .sys_clk        (sys_clk),
      .sys_rst        (sys_rst),
      .sampleValid    (coarseStrobe),
      .shapedI        (shapedI),
      .shapedQ        (shapedQ),
      .rampGain       (rampGain),
      .gainMultiplier (gainMultiplier),
      .gainShiftCode  (gainShiftCode),
      .gainI_q        (gainI),
      .gainQ_q        (gainQ),
      .gainValid_q    (gainValid)
   );

endmodule // channel_gain_and_sample_nco

// *** pkg/channel_gain_consts.vh ***
`ifndef CHANNEL_GAIN_CONSTS_VH
`define CHANNEL_GAIN_CONSTS_VH

// ----------------------------------------------------------------
// control word offsets (16-bit words on the host port)
// ----------------------------------------------------------------
`define OFS_LEAP_DIV_HIGH    8'h02
`define OFS_LEAP_DIV_LOW     8'h03
`define OFS_SAMPLE_INC_HIGH  8'h04
`define OFS_SAMPLE_INC_MID   8'h05
`define OFS_SAMPLE_INC_LOW   8'h06
`define OFS_GAIN_CONTROL     8'h0a
`define OFS_RAMP_LEN_LAT     8'h0b
`define OFS_MAIN_CONTROL     8'h0c
`define OFS_FILTER_CONTROL   8'h0d
`define OFS_RAMP_MEM_ADDR    8'h10
`define OFS_RAMP_MEM_DATA    8'h11
`define OFS_CHANNEL_STATUS   8'h12

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_RAMP_ENABLE      15
`define BIT_LEAP_CLR_FINE    14
`define BIT_LEAP_CLR_COARSE  13
`define BIT_LEAP_ENABLE      12
`define BIT_OFFSET_HI        11
`define BIT_OFFSET_LO        10
`define BIT_IP_SEL_HI        1
`define BIT_IP_SEL_LO        0
`define BIT_RAMP_HOLD        14
`define BIT_LAT_BYPASS       8
`define BIT_LAT_REDUCED      7
`define BIT_RAMP_LEN_HI      6
`define BIT_GAIN_SHIFT_HI    14
`define BIT_GAIN_SHIFT_LO    12
`define BIT_GAIN_MULT_HI     11

// ----------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------
`define RST_WORD             16'h0000
`define RAMP_UNITY           12'h800
`define RAMP_ALIGN_DEPTH     4
`define RAMP_LAT_REDUCTION   2
`define RAMP_MEM_DEPTH       128
`define IP_SEL_4             2'b00
`define IP_SEL_8             2'b01

`endif

// *** rtl/ramp_gain_profile.v ***
`timescale 1ns/10ps
`include "channel_gain_consts.vh"

module ramp_gain_profile #(
   parameter ALIGN_DEPTH = `RAMP_ALIGN_DEPTH
) (
   input  wire        sys_clk,
   input  wire        sys_rst,
   input  wire        coarseStrobe,
   input  wire        txBurstEnable,
   input  wire        rampEnable,
   input  wire        rampHold,
   input  wire        latBypass,
   input  wire        latReduced,
   input  wire [6:0]  rampLength,
   input  wire [6:0]  memAddr,
   input  wire [11:0] memWrData,
   input  wire        memWr,
   output wire [11:0] memRdData,
   output reg  [11:0] rampGain_q,
   output reg  [6:0]  rampPtr_q,
   output wire        txEffective
);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   reg [11:0]            profMem [0:`RAMP_MEM_DEPTH-1];
   reg [ALIGN_DEPTH-1:0] alignLine_q;
   reg                   rampEnPrev_q;
   wire                  memOpen;

   // host writes only while the gain cannot glitch from a rewrite; reads are always open
   assign memOpen   = ~rampEnable | rampHold;
   assign memRdData = profMem[memAddr];

   // coefficient writes, 128 x 12
   always @(posedge sys_clk) begin
      if (memWr && memOpen) begin
         profMem[memAddr] <= memWrData;
      end
   end

   // ----------------------------------------------------------------
   // burst enable alignment
   // ----------------------------------------------------------------
   // delay line steps on coarse ticks, so latency is in edges not clocks
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         alignLine_q <= {ALIGN_DEPTH{1'b0}};
      end else if (coarseStrobe) begin
         alignLine_q <= {alignLine_q[ALIGN_DEPTH-2:0], txBurstEnable};
      end
   end

   // bypass uses the raw pin; reduced mode taps two edges earlier
   assign txEffective = latBypass  ? txBurstEnable :
                        latReduced ? alignLine_q[ALIGN_DEPTH-1-`RAMP_LAT_REDUCTION] :
                                     alignLine_q[ALIGN_DEPTH-1];

   // ----------------------------------------------------------------
   // pointer walk
   // ----------------------------------------------------------------
   // up toward the length while txEffective is high, down to zero while it is low; frozen while the ramp is off or on hold
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         rampPtr_q    <= 7'h00;
         rampEnPrev_q <= 1'b0;
      end else begin
         rampEnPrev_q <= rampEnable;
         if (rampEnable && !rampEnPrev_q) begin
            rampPtr_q <= 7'h00;
         end else if (rampEnable && !rampHold && coarseStrobe) begin
            if (txEffective && (rampPtr_q != rampLength)) begin
               rampPtr_q <= rampPtr_q + 7'h01;
            end else if (!txEffective && (rampPtr_q != 7'h00)) begin
               rampPtr_q <= rampPtr_q - 7'h01;
            end
         end
      end
   end

   // applied gain: unity when off, frozen on hold, table value otherwise
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         rampGain_q <= `RAMP_UNITY;
      end else if (!rampEnable) begin
         rampGain_q <= `RAMP_UNITY;
      end else if (!rampHold) begin
         rampGain_q <= profMem[rampPtr_q];
      end
   end

endmodule // ramp_gain_profile

// *** rtl/gain_scaler.v ***
`timescale 1ns/10ps
`include "channel_gain_consts.vh"

module gain_scaler #(
   parameter DW = 16
) (
   input  wire                 sys_clk,
   input  wire                 sys_rst,
   input  wire                 sampleValid,
   input  wire signed [DW-1:0] shapedI,
   input  wire signed [DW-1:0] shapedQ,
   input  wire [11:0]          rampGain,
   input  wire [11:0]          gainMultiplier,
   input  wire [2:0]           gainShiftCode,
   output reg  signed [DW+1:0] gainI_q,
   output reg  signed [DW+1:0] gainQ_q,
   output reg                  gainValid_q
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // divisors 4096,256,32,16,8,4,2,1 as right-shift counts
   function [3:0] shiftCount;
      input [2:0] code;
      begin
         case (code)
            3'h0:    shiftCount = 4'hc;
            3'h1:    shiftCount = 4'h8;
            3'h2:    shiftCount = 4'h5;
            3'h3:    shiftCount = 4'h4;
            3'h4:    shiftCount = 4'h3;
            3'h5:    shiftCount = 4'h2;
            3'h6:    shiftCount = 4'h1;
            default: shiftCount = 4'h0;
         endcase
      end
   endfunction

   // ramp stage: 1.11 unsigned coefficient, 0x800 is unity
   wire signed [DW+12:0] rampProdI = shapedI * $signed({1'b0, rampGain});
   wire signed [DW+12:0] rampProdQ = shapedQ * $signed({1'b0, rampGain});

   reg  signed [DW+1:0]  rampI_q;
   reg  signed [DW+1:0]  rampQ_q;
   reg                   rampValid_q;

   // gain stage: multiplier over 4096, never above unity
   wire signed [DW+14:0] multProdI = rampI_q * $signed({1'b0, gainMultiplier});
   wire signed [DW+14:0] multProdQ = rampQ_q * $signed({1'b0, gainMultiplier});
   wire signed [DW+1:0]  multI     = multProdI[DW+13:12];
   wire signed [DW+1:0]  multQ     = multProdQ[DW+13:12];

   // ----------------------------------------------------------------
   // pipeline
   // ----------------------------------------------------------------
   // ramp first, then multiplier and shift; same scaling on I and Q
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         rampI_q     <= {(DW+2){1'b0}};
         rampQ_q     <= {(DW+2){1'b0}};
         rampValid_q <= 1'b0;
         gainI_q     <= {(DW+2){1'b0}};
         gainQ_q     <= {(DW+2){1'b0}};
         gainValid_q <= 1'b0;
      end else begin
         rampValid_q <= sampleValid;
         gainValid_q <= rampValid_q;
         if (sampleValid) begin
            rampI_q <= rampProdI[DW+12:11];
            rampQ_q <= rampProdQ[DW+12:11];
         end
         if (rampValid_q) begin
            gainI_q <= multI >>> shiftCount(gainShiftCode);
            gainQ_q <= multQ >>> shiftCount(gainShiftCode);
         end
      end
   end

endmodule // gain_scaler

// *** tb/channel_gain_props.sv ***
`timescale 1ns/10ps
module channel_gain_props #(
   parameter DW          = 16,
   parameter ALIGN_DEPTH = 4
) (
   input wire                 sys_clk,
   input wire                 sys_rst,
   input wire        [7:0]    hostAddr,
   input wire        [15:0]   hostWrData,
   input wire                 hostWr,
   input wire                 hostRd,
   input wire        [15:0]   hostRdData_q,
   input wire signed [DW+1:0] gainI,
   input wire signed [DW+1:0] gainQ,
   input wire                 gainValid,
   input wire                 sampleClock_q,
   input wire                 sampleStrobe,
   input wire                 coarseStrobe,
   input wire        [3:0]    coarsePhase_q,
   input wire        [15:0]   finePhase_q,
   input wire                 leapCarry,
   input wire                 leapPreCarry
);
   logic [15:0] gainCtl_q;
   logic [15:0] firCtl_q;
   // ------------------------------------------
   // shadow of host writes, reset like the block
   // ------------------------------------------
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         gainCtl_q <= 16'h0000;
         firCtl_q  <= 16'h0000;
      end else if (hostWr) begin
         if (hostAddr == 8'h0a) gainCtl_q <= hostWrData;
         if (hostAddr == 8'h0d) firCtl_q <= hostWrData;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // timing of the sample path, both directions
   a_valid_after_sample: assert property (gainValid |-> $past(coarseStrobe, 2))
      else $error("gain valid without sample");
   a_sample_gives_valid: assert property (coarseStrobe |-> ##2 gainValid)
      else $error("sample without gain valid");
   a_gain_output_hold: assert property (!gainValid |-> $stable(gainI) && $stable(gainQ))
      else $error("gain output moved without valid");
   a_gain_word_read: assert property (hostRd && hostAddr == 8'h0a |=> hostRdData_q == $past(gainCtl_q))
      else $error("gain control readback wrong");
   a_precarry_leads: assert property (leapCarry |-> $past(leapPreCarry))
      else $error("carry without precarry");
   a_coarse_step_seen: assert property (coarseStrobe |-> coarsePhase_q[0] != $past(coarsePhase_q[0]))
      else $error("coarse strobe without phase step");
   a_msb_in_coarse: assert property ($changed(sampleClock_q) |-> $changed(coarsePhase_q))
      else $error("sample clock moved alone");
   a_strobe_before_rise: assert property (sampleStrobe |=> $rose(sampleClock_q))
      else $error("sample strobe without sample clock rise");
   a_leap_fine_clear: assert property (leapCarry && firCtl_q[14] |-> ##2 finePhase_q == 16'h0000)
      else $error("fine phase not cleared");
   a_leap_coarse_clear: assert property (leapCarry && firCtl_q[13] && firCtl_q[11:10] == 2'b00
      |-> ##2 coarsePhase_q == 4'h0)
      else $error("coarse phase not cleared");
   c_gain_valid: cover property (gainValid);
   c_leap_clear: cover property (leapCarry && firCtl_q[14]);
   c_sample_rise: cover property ($rose(sampleClock_q));
endmodule // channel_gain_props

// *** tb/shaping_filter_model.sv ***
`timescale 1ns/10ps
module shaping_filter_model (
   input  wire                sys_clk,
   input  wire                sys_rst,
   input  wire                coarseStrobe,
   output logic signed [15:0] shapedI = 16'h0000,
   output logic signed [15:0] shapedQ = 16'h0000
);
   integer r;
   integer seed = 14;
   // new pair after each coarse step; full scale now and then as a corner
   always @(posedge sys_clk) begin
      r = $random(seed);
      if (sys_rst) begin
         shapedI <= 16'h0000;
         shapedQ <= 16'h0000;
      end else if (coarseStrobe) begin
         shapedI <= (r[2:0] == 3'h0) ? 16'h8000 : r[15:0];
         shapedQ <= (r[2:0] == 3'h0) ? 16'h7fff : r[31:16];
      end
   end
endmodule // shaping_filter_model

// *** tb/channel_gain_and_sample_nco_bench.sv ***
`timescale 1ns/10ps
`define CHK(a,b) begin compares++; if ((a) !== (b)) begin n_errors++; $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
bind channel_gain_and_sample_nco channel_gain_props #(.DW(DW), .ALIGN_DEPTH(ALIGN_DEPTH))
   channel_gain_props_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .hostAddr(hostAddr),
   .hostWrData(hostWrData), .hostWr(hostWr), .hostRd(hostRd), .hostRdData_q(hostRdData_q),
   .gainI(gainI), .gainQ(gainQ), .gainValid(gainValid), .sampleClock_q(sampleClock_q),
   .coarseStrobe(coarseStrobe), .coarsePhase_q(coarsePhase_q), .finePhase_q(finePhase_q),
   .leapCarry(leapCarry), .leapPreCarry(leapPreCarry), .sampleStrobe(sampleStrobe));
module channel_gain_and_sample_nco_bench;
   logic sys_clk = 1'b0, sys_rst = 1'b1, hostWr = 1'b0, hostRd = 1'b0, txBurstEnable = 1'b0;
   logic [7:0] hostAddr = 8'h00;
   logic [15:0] hostWrData = 16'h0000, hostRdData_q, finePhase_q;
   logic signed [15:0] shapedI, shapedQ;
   logic signed [17:0] gainI, gainQ, expI, expQ;
   logic gainValid, sampleClock_q, coarseStrobe, leapCarry, leapPreCarry;
   logic checkOn = 1'b0, armed = 1'b0;
   logic [3:0] coarsePhase_q;
   logic [11:0] tbRamp = 12'h800, tbMult = 12'h000;
   logic [2:0] tbCode = 3'h0;
   integer n_errors = 0, compares = 0, seed = 14, i, k;
   always #10 sys_clk = ~sys_clk;
   channel_gain_and_sample_nco channel_gain_and_sample_nco_inst (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .hostAddr(hostAddr), .hostWrData(hostWrData), .hostWr(hostWr),
      .hostRd(hostRd), .hostRdData_q(hostRdData_q), .txBurstEnable(txBurstEnable),
      .shapedI(shapedI), .shapedQ(shapedQ), .gainI(gainI), .gainQ(gainQ), .gainValid(gainValid),
      .sampleClock_q(sampleClock_q), .sampleStrobe(), .coarseStrobe(coarseStrobe),
      .coarsePhase_q(coarsePhase_q), .finePhase_q(finePhase_q), .leapCarry(leapCarry),
      .leapPreCarry(leapPreCarry));
   shaping_filter_model shaping_filter_model_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .coarseStrobe(coarseStrobe), .shapedI(shapedI), .shapedQ(shapedQ));
   // ramp, then multiplier, then shift, floor at each step
   function automatic logic signed [17:0] calc(input logic signed [15:0] x);
      longint p;
      p = (longint'(x) * longint'(tbRamp)) >>> 11;
      p = (p * longint'(tbMult)) >>> 12;
      p = p >>> ((tbCode == 3'h0) ? 12 : (tbCode == 3'h1) ? 8 : 7 - tbCode);
      return p[17:0];
   endfunction
   // expectation taken at the sample edge, judged two edges later
   always @(posedge sys_clk) begin
      if (!checkOn) armed = 1'b0;
      if (armed && gainValid === 1'b1) begin
         `CHK(gainI, expI)
         `CHK(gainQ, expQ)
         armed = 1'b0;
      end
      if (coarseStrobe === 1'b1) begin
         expI = calc(shapedI);
         expQ = calc(shapedQ);
         armed = checkOn;
      end
   end
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      hostAddr <= a;
      hostWrData <= d;
      hostWr <= 1'b1;
      @(posedge sys_clk);
      hostWr <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge sys_clk);
      hostAddr <= a;
      hostRd <= 1'b1;
      @(posedge sys_clk);
      hostRd <= 1'b0;
      @(negedge sys_clk);
      `CHK(hostRdData_q & m, e)
   endtask
   task automatic settle;
      repeat (40) @(posedge sys_clk);
      checkOn <= 1'b1;
   endtask
   // pipeline checks paused while a setting lands
   task automatic apply(input logic [7:0] a, input logic [15:0] d);
      checkOn <= 1'b0;
      wr(a, d);
      settle;
   endtask
   task automatic strobes(input integer n);
      repeat (n) begin
         @(negedge sys_clk);
         while (coarseStrobe !== 1'b1) @(negedge sys_clk);
      end
   endtask
   task automatic give_verdict;
      if (n_errors == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      give_verdict;
   end
   // ------------------------------------------
   // main sequence
   // ------------------------------------------
   initial begin
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rdchk(8'h0a, 16'hffff, 16'h0000);
      rdchk(8'h3f, 16'hffff, 16'h0000);
      wr(8'h0d, 16'h0002);
      wr(8'h04, 16'h0200);
      rdchk(8'h04, 16'hffff, 16'h0200);
      for (i = 0; i < 8; i++) begin
         k = (i == 7) ? 32'h00000fff : $random(seed);
         apply(8'h0a, {1'b0, i[2:0], k[11:0]});
         tbCode = i[2:0];
         tbMult = k[11:0];
         rdchk(8'h0a, 16'hffff, {1'b0, i[2:0], k[11:0]});
         repeat (40) @(posedge sys_clk);
      end
      checkOn <= 1'b0;
      for (i = 0; i < 8; i++) begin
         wr(8'h10, {9'h000, i[6:0]});
         wr(8'h11, {4'h0, i[3:0], 8'h00});
      end
      rdchk(8'h11, 16'h0fff, 16'h0700);
      wr(8'h0d, 16'h8002);
      for (i = 0; i < 3; i++) begin
         wr(8'h0b, (i == 0) ? 16'h0105 : (i == 1) ? 16'h0085 : 16'h0005);
         @(posedge sys_clk) txBurstEnable <= 1'b1;
         strobes(3);
         rdchk(8'h12, 16'h0100, (i < 2) ? 16'h0100 : 16'h0000);
         repeat (200) @(posedge sys_clk);
         rdchk(8'h12, 16'h007f, 16'h0005);
         if (i < 2) begin
            @(posedge sys_clk) txBurstEnable <= 1'b0;
            repeat (200) @(posedge sys_clk);
            rdchk(8'h12, 16'h007f, 16'h0000);
         end
      end
      tbRamp = 12'h500;
      settle;
      apply(8'h0c, 16'h4000);
      wr(8'h10, 16'h0005);
      wr(8'h11, 16'h0800);
      rdchk(8'h11, 16'h0fff, 16'h0800);
      repeat (40) @(posedge sys_clk);
      apply(8'h0c, 16'h0000);
      tbRamp = 12'h800;
      repeat (40) @(posedge sys_clk);
      checkOn <= 1'b0;
      wr(8'h0d, 16'h0002);
      @(posedge sys_clk) txBurstEnable <= 1'b0;
      repeat (100) @(posedge sys_clk);
      wr(8'h0d, 16'h8002);
      rdchk(8'h12, 16'h007f, 16'h0000);
      wr(8'h0d, 16'h0002);
      wr(8'h03, 16'h0005);
      rdchk(8'h03, 16'hffff, 16'h0005);
      wr(8'h0d, 16'h7802);
      @(negedge sys_clk);
      while (leapCarry !== 1'b1) @(negedge sys_clk);
      k = 0;
      do begin
         @(negedge sys_clk);
         k++;
      end while (leapCarry !== 1'b1);
      `CHK(k, 5)
      repeat (2) @(negedge sys_clk);
      `CHK(coarsePhase_q, 4'h8)
      `CHK(finePhase_q, 16'h0000)
      wr(8'h0d, 16'h3002);
      repeat (20) @(posedge sys_clk);
      wr(8'h0d, 16'h0002);
      give_verdict;
   end
endmodule // channel_gain_and_sample_nco_bench
